/* File: shared/qsel_consts.svh */
`ifndef QSEL_CONSTS_SVH
`define QSEL_CONSTS_SVH

// ----------------------------------------------------------------
// Option-select register indices on the setup port
// ----------------------------------------------------------------
`define QSEL_IDX_ID_LO      3'h0
`define QSEL_IDX_ID_HI      3'h1
`define QSEL_IDX_IRQ_BLK    3'h2
`define QSEL_IDX_EN_ADDR    3'h3
`define QSEL_IDX_ADDR_CEN   3'h4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define QSEL_RST_BYTE       8'h00
`define QSEL_RST_IRQ        1'h0

// ----------------------------------------------------------------
// Field positions, irq_and_block_config
// ----------------------------------------------------------------
`define QSEL_SUMSEL_BIT     7
`define QSEL_PAIR_BIT       6
`define QSEL_LINE_HI        5
`define QSEL_LINE_LO        2
`define QSEL_BLOCK_BIT      1
`define QSEL_EN4_BIT        0

// ----------------------------------------------------------------
// Field positions, enable/address registers
// ----------------------------------------------------------------
`define QSEL_EN3_BIT        7
`define QSEL_EN2_BIT        6
`define QSEL_EN1_BIT        5
`define QSEL_CEN_BIT        0
`define QSEL_BLK_HI_MSB     3
`define QSEL_BLK_LO_MSB     7
`define QSEL_BLK_LO_LSB     1

// ----------------------------------------------------------------
// Host address fields
// ----------------------------------------------------------------
`define QSEL_CHAN_OFS_MSB   2
`define QSEL_SLOT_MSB       15
`define QSEL_SLOT_LSB       3
`define QSEL_BLK_A_LSB      5
`define QSEL_BLK_CH_MSB     4
`define QSEL_BLK_CH_LSB     3
`define QSEL_SCRATCH_OFS    3'h7

// ----------------------------------------------------------------
// Slot base addresses, codes 000 to 111
// ----------------------------------------------------------------
`define QSEL_SLOT_BASE0     16'h03F8
`define QSEL_SLOT_BASE1     16'h02F8
`define QSEL_SLOT_BASE2     16'h3220
`define QSEL_SLOT_BASE3     16'h3228
`define QSEL_SLOT_BASE4     16'h4220
`define QSEL_SLOT_BASE5     16'h4228
`define QSEL_SLOT_BASE6     16'h5220
`define QSEL_SLOT_BASE7     16'h5228
`define QSEL_SLOT_LOW_BAR   3'h7
`define QSEL_SLOT_HIGH_BAR  3'h0

`endif

/* File: shared/qsel_pkg.sv */
`default_nettype none

package qsel_pkg;
	typedef logic [7:0]  qsel_byte_t;
	typedef logic [15:0] qsel_addr_t;
	typedef logic [2:0]  qsel_code_t;
	typedef logic [2:0]  qsel_idx_t;
endpackage

`default_nettype wire

/* File: design/qsel_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qsel_consts.svh"

// Function
// R01: Slot mode limits channel slot ranges
// R02: Block mode uses one aligned 32-byte window
// R03: Block window offsets map channels in order
// R04: Cleared channel enable blocks that channel
// R05: Host keeps disabled block range reserved
// R06: Slot codes select fixed base addresses
// R07: Block mode compares A15-A5 to address bits
// R08: Block enable bit selects addressing mode
// R09: Pair and line bits route interrupts
// R10: Summary bits show gated pending interrupts
// R11: Second user output gates channel interrupt
// R12: Summary select overrides scratchpad reads
// R13: Summary register ignores host writes
// R14: Identification registers fixed and read-only
// R15: Three read/write option registers exist
// R16: Each channel spans eight aligned addresses
// R17: Card enable gates decode and interrupts
// R18: Summary select lives at bit seven
// R19: Shared interrupt lines are ORed
module qsel_top #(
	parameter int               NUM_CHAN   = 4,
	parameter logic [15:0]      ADAPTER_ID = 16'hA5C3  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	// Option-select setup port
	input  wire logic                   cfg_sel,
	input  wire logic [2:0]             cfg_idx,
	input  wire logic                   cfg_rd,
	input  wire logic                   cfg_wr,
	input  wire logic [7:0]             cfg_wdata,
	output logic [7:0]                  cfg_rdata,
	// Host I/O cycle
	input  wire logic [15:0]            io_addr,
	input  wire logic                   io_rd,
	input  wire logic                   io_wr,
	output logic [7:0]                  io_rdata,
	output logic                        io_rdata_oe,
	// Channel strobes towards the UARTs
	output logic [NUM_CHAN-1:0]         chan_rd,
	output logic [NUM_CHAN-1:0]         chan_wr,
	// Channel interrupt sources
	input  wire logic [NUM_CHAN-1:0]    uart_irq,
	input  wire logic [NUM_CHAN-1:0]    second_user_output_n,
	// Host interrupt lines
	output logic                        irq3,
	output logic                        irq4,
	output logic                        irq9
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	generate
		if (NUM_CHAN != 4)
		begin : g_bad_chan
			$error("qsel_top serves exactly four channels");
		end
	endgenerate

	// ------------------------------------------------------------
	// Option-select registers
	// ------------------------------------------------------------
	qsel_pkg::qsel_byte_t   irq_and_block_config_reg;
	qsel_pkg::qsel_byte_t   channel_enable_and_addr_hi_reg;
	qsel_pkg::qsel_byte_t   addr_low_and_card_enable_reg;
	qsel_pkg::qsel_byte_t   pending_interrupt_summary_reg;
	qsel_pkg::qsel_byte_t   pending_interrupt_summary_next;
	qsel_pkg::qsel_byte_t   cfg_rdata_next;
	logic                   irq3_next;
	logic                   irq4_next;
	logic                   irq9_next;

	wire wr_irq_blk  = cfg_sel & cfg_wr & (cfg_idx == `QSEL_IDX_IRQ_BLK);
	wire wr_en_addr  = cfg_sel & cfg_wr & (cfg_idx == `QSEL_IDX_EN_ADDR);
	wire wr_addr_cen = cfg_sel & cfg_wr & (cfg_idx == `QSEL_IDX_ADDR_CEN);

	// Only the three option registers take writes; id indices fall away
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_and_block_config_reg       <= `QSEL_RST_BYTE;
			channel_enable_and_addr_hi_reg <= `QSEL_RST_BYTE;
			addr_low_and_card_enable_reg   <= `QSEL_RST_BYTE;
		end
		else
		begin
			if (wr_irq_blk)
				irq_and_block_config_reg <= cfg_wdata;        // R15
			if (wr_en_addr)
				channel_enable_and_addr_hi_reg <= cfg_wdata;  // R15
			if (wr_addr_cen)
				addr_low_and_card_enable_reg <= cfg_wdata;    // R15
		end
	end

	// ------------------------------------------------------------
	// Setup port read mux
	// ------------------------------------------------------------
	wire cfg_rd_hit = cfg_sel & cfg_rd;

	always_comb
	begin
		if (!cfg_rd_hit)
			cfg_rdata_next = cfg_rdata;
		else if (cfg_idx == `QSEL_IDX_ID_LO)
			cfg_rdata_next = ADAPTER_ID[7:0];                // R14
		else if (cfg_idx == `QSEL_IDX_ID_HI)
			cfg_rdata_next = ADAPTER_ID[15:8];               // R14
		else if (cfg_idx == `QSEL_IDX_IRQ_BLK)
			cfg_rdata_next = irq_and_block_config_reg;
		else if (cfg_idx == `QSEL_IDX_EN_ADDR)
			cfg_rdata_next = channel_enable_and_addr_hi_reg;
		else if (cfg_idx == `QSEL_IDX_ADDR_CEN)
			cfg_rdata_next = addr_low_and_card_enable_reg;
		else
			cfg_rdata_next = `QSEL_RST_BYTE;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_rdata <= `QSEL_RST_BYTE;
		else
			cfg_rdata <= cfg_rdata_next;
	end

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	wire summary_select  = irq_and_block_config_reg[`QSEL_SUMSEL_BIT]; // R18
	wire irq_pair_select = irq_and_block_config_reg[`QSEL_PAIR_BIT];
	wire block_mode_enable = irq_and_block_config_reg[`QSEL_BLOCK_BIT];
	wire card_enable     = addr_low_and_card_enable_reg[`QSEL_CEN_BIT];
	wire [NUM_CHAN-1:0] line_select =
		irq_and_block_config_reg[`QSEL_LINE_HI:`QSEL_LINE_LO];
	wire [NUM_CHAN-1:0] chan_enable_bit = {
		irq_and_block_config_reg[`QSEL_EN4_BIT],
		channel_enable_and_addr_hi_reg[`QSEL_EN3_BIT],
		channel_enable_and_addr_hi_reg[`QSEL_EN2_BIT],
		channel_enable_and_addr_hi_reg[`QSEL_EN1_BIT]};

	// Eleven address-select bits, upper ones first; the top slot bit
	// of channel four has no address line behind it
	wire [10:0] address_select_bits = {
		channel_enable_and_addr_hi_reg[`QSEL_BLK_HI_MSB:0],
		addr_low_and_card_enable_reg[`QSEL_BLK_LO_MSB:`QSEL_BLK_LO_LSB]};

	// Slot codes share the same bits as the block address
	wire [3*NUM_CHAN-1:0] slot_codes = {
		channel_enable_and_addr_hi_reg[4:2],
		channel_enable_and_addr_hi_reg[1:0],
		addr_low_and_card_enable_reg[7:1]};

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic qsel_pkg::qsel_addr_t slot_base(
		input qsel_pkg::qsel_code_t code
	);
		case (code)
			3'h0:    slot_base = `QSEL_SLOT_BASE0;
			3'h1:    slot_base = `QSEL_SLOT_BASE1;
			3'h2:    slot_base = `QSEL_SLOT_BASE2;
			3'h3:    slot_base = `QSEL_SLOT_BASE3;
			3'h4:    slot_base = `QSEL_SLOT_BASE4;
			3'h5:    slot_base = `QSEL_SLOT_BASE5;
			3'h6:    slot_base = `QSEL_SLOT_BASE6;
			default: slot_base = `QSEL_SLOT_BASE7;
		endcase
	endfunction

	wire block_hit = address_select_bits ==
		io_addr[`QSEL_SLOT_MSB:`QSEL_BLK_A_LSB];                      // R07
	wire [1:0] block_chan = io_addr[`QSEL_BLK_CH_MSB:`QSEL_BLK_CH_LSB];
	wire scratch_ofs =
		io_addr[`QSEL_CHAN_OFS_MSB:0] == `QSEL_SCRATCH_OFS;

	// Nets, since every bit has its own continuous assignment
	wire [NUM_CHAN-1:0] chan_hit;
	wire [NUM_CHAN-1:0] second_user_output_active;
	wire [NUM_CHAN-1:0] chan_irq_gated;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi = gi + 1)
		begin : g_chan
			wire [2:0] code = slot_codes[3*gi+2:3*gi];
			// Low pair stops at slot seven, high pair starts at two
			wire slot_legal = (gi < 2) ? (code != `QSEL_SLOT_LOW_BAR)
				: (code != `QSEL_SLOT_HIGH_BAR);                        // R01
			wire qsel_pkg::qsel_addr_t base = slot_base(code);      // R06
			// Eight aligned bytes per channel
			wire slot_hit = slot_legal &
				(io_addr[`QSEL_SLOT_MSB:`QSEL_SLOT_LSB] ==
				base[`QSEL_SLOT_MSB:`QSEL_SLOT_LSB]);                   // R16
			wire blk_hit = block_hit & (block_chan == 2'(gi));      // R03
			assign chan_hit[gi] = card_enable & chan_enable_bit[gi] &
				(block_mode_enable ? blk_hit : slot_hit);   // R02 R04 R08 R17
			assign second_user_output_active[gi] = ~second_user_output_n[gi];
			assign chan_irq_gated[gi] = uart_irq[gi] & second_user_output_active[gi]; // R11
		end
	endgenerate

	// Scratchpad cycle that the summary register takes over
	wire summary_cycle = summary_select & scratch_ofs & (|chan_hit);

	// Summary writes are swallowed, UART scratchpad untouched too
	assign chan_rd = summary_cycle ? '0 : (chan_hit & {NUM_CHAN{io_rd}});
	assign chan_wr = summary_cycle ? '0 : (chan_hit & {NUM_CHAN{io_wr}});
	assign io_rdata_oe = summary_cycle & io_rd;                       // R12

	// ------------------------------------------------------------
	// Pending summary
	// ------------------------------------------------------------
	// Sampled every cycle so the read data is a flip-flop output;
	// the price is one cycle of lag behind the UART pins
	assign pending_interrupt_summary_next =
		{4'h0, chan_irq_gated};                                       // R10

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			pending_interrupt_summary_reg <= `QSEL_RST_BYTE;
		else
			pending_interrupt_summary_reg <=
				pending_interrupt_summary_next;                          // R13
	end

	assign io_rdata = pending_interrupt_summary_reg;

	// ------------------------------------------------------------
	// Interrupt routing
	// ------------------------------------------------------------
	wire [NUM_CHAN-1:0] to_irq3 = chan_irq_gated & ~line_select;
	wire [NUM_CHAN-1:0] to_alt  = chan_irq_gated & line_select;

	assign irq3_next = card_enable & (|to_irq3);                  // R09 R19
	assign irq4_next = card_enable & ~irq_pair_select & (|to_alt); // R09
	assign irq9_next = card_enable & irq_pair_select & (|to_alt);  // R09

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq3 <= `QSEL_RST_IRQ;
			irq4 <= `QSEL_RST_IRQ;
			irq9 <= `QSEL_RST_IRQ;
		end
		else
		begin
			irq3 <= irq3_next;                                        // R17
			irq4 <= irq4_next;
			irq9 <= irq9_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_card_off_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		!card_enable |-> (chan_rd == '0) && (chan_wr == '0);
	endproperty
	a_card_off_quiet: assert property (p_card_off_quiet) // R17
		else $error("strobe while card disabled");

	property p_card_off_irq;
		@(posedge ref_clk) disable iff (!nrst)
		!card_enable ##1 !$past(card_enable) |-> !irq3 && !irq4 && !irq9;
	endproperty
	a_card_off_irq: assert property (p_card_off_irq) // R17
		else $error("irq raised while card disabled");

	property p_slot1_hit;
		@(posedge ref_clk) disable iff (!nrst)
		card_enable && !block_mode_enable && chan_enable_bit[0] &&
		slot_codes[2:0] == 3'h0 && io_rd &&
		io_addr[15:3] == 13'h007F && !summary_cycle |-> chan_rd[0];
	endproperty
	a_slot1_hit: assert property (p_slot1_hit) // R06
		else $error("slot one decode missed");

	property p_low_pair_bar;
		@(posedge ref_clk) disable iff (!nrst)
		!block_mode_enable && slot_codes[2:0] == 3'h7 |->
		!chan_rd[0] && !chan_wr[0];
	endproperty
	a_low_pair_bar: assert property (p_low_pair_bar) // R01
		else $error("channel one decoded slot eight");

	property p_block_map;
		@(posedge ref_clk) disable iff (!nrst)
		card_enable && block_mode_enable && io_wr && (&chan_enable_bit)
		&& address_select_bits == io_addr[15:5] && !summary_cycle |->
		chan_wr == (4'h1 << io_addr[4:3]);
	endproperty
	a_block_map: assert property (p_block_map) // R03
		else $error("block window channel wrong");

	property p_disabled_chan;
		@(posedge ref_clk) disable iff (!nrst)
		!chan_enable_bit[2] |-> !chan_rd[2] && !chan_wr[2];
	endproperty
	a_disabled_chan: assert property (p_disabled_chan) // R04
		else $error("disabled channel answered");

	property p_summary_follow;
		@(posedge ref_clk) disable iff (!nrst)
		1'b1 |=> io_rdata ==
		{4'h0, $past(uart_irq) & ~$past(second_user_output_n)};
	endproperty
	a_summary_follow: assert property (p_summary_follow) // R10
		else $error("summary bits wrong");

	property p_irq9_route;
		@(posedge ref_clk) disable iff (!nrst)
		card_enable && irq_pair_select && chan_irq_gated[1] &&
		line_select[1] |=> irq9 && !irq4;
	endproperty
	a_irq9_route: assert property (p_irq9_route) // R09
		else $error("pair one channel not on line nine");

	property p_summary_override;
		@(posedge ref_clk) disable iff (!nrst)
		summary_select && io_rd && scratch_ofs && (|chan_hit) |->
		io_rdata_oe && chan_rd == '0;
	endproperty
	a_summary_override: assert property (p_summary_override) // R12
		else $error("scratchpad not overridden");

	property p_id_fixed;
		@(posedge ref_clk) disable iff (!nrst)
		cfg_sel && cfg_rd && cfg_idx == `QSEL_IDX_ID_HI |=>
		cfg_rdata == ADAPTER_ID[15:8];
	endproperty
	a_id_fixed: assert property (p_id_fixed) // R14
		else $error("identification byte changed");

endmodule

`default_nettype wire

/* File: dv/qsel_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module qsel_host_model (
	// Clock
	input  wire logic        ref_clk,
	// Setup port
	output logic             cfg_sel,
	output logic [2:0]       cfg_idx,
	output logic             cfg_rd,
	output logic             cfg_wr,
	output logic [7:0]       cfg_wdata,
	input  wire logic [7:0]  cfg_rdata,
	// Host I/O cycle
	output logic [15:0]      io_addr,
	output logic             io_rd,
	output logic             io_wr,
	input  wire logic [3:0]  chan_rd,
	input  wire logic [3:0]  chan_wr,
	input  wire logic        io_rdata_oe
);
	initial
	begin
		cfg_sel = 1'b0;
		cfg_idx = 3'h0;
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_wdata = 8'h00;
		io_addr = 16'h0000;
		io_rd = 1'b0;
		io_wr = 1'b0;
	end

	// -------------------------------------------
	// Setup cycles, issued by configuration only
	// -------------------------------------------
	task automatic cfg_write(logic [2:0] idx, logic [7:0] data);
		@(posedge ref_clk);
		#1;
		cfg_sel = 1'b1;
		cfg_wr = 1'b1;
		cfg_idx = idx;
		cfg_wdata = data;
		@(posedge ref_clk);
		#1;
		cfg_sel = 1'b0;
		cfg_wr = 1'b0;
		// Released data must not look valid
		cfg_wdata = ~data;
	endtask

	task automatic cfg_read(logic [2:0] idx, output logic [7:0] data);
		@(posedge ref_clk);
		#1;
		cfg_sel = 1'b1;
		cfg_rd = 1'b1;
		cfg_idx = idx;
		@(posedge ref_clk);
		#1;
		data = cfg_rdata;
		cfg_sel = 1'b0;
		cfg_rd = 1'b0;
	endtask

	// -------------------------------------------
	// Host I/O cycle, strobes sampled at the edge
	// -------------------------------------------
	task automatic io_cycle(logic [15:0] a, logic rd,
		output logic [8:0] got);
		@(posedge ref_clk);
		#1;
		io_addr = a;
		io_rd = rd;
		io_wr = !rd;
		@(posedge ref_clk);
		got = {io_rdata_oe, chan_rd, chan_wr};
		#1;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_addr = ~a;
	endtask
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qsel_consts.svh"

module tb_top;
	// -------------------------------------------
	// Signals
	// -------------------------------------------
	localparam logic [15:0] ID = 16'h3C96; // Arbitrary value
	localparam logic [15:0] SLOT [8] = '{`QSEL_SLOT_BASE0,
		`QSEL_SLOT_BASE1, `QSEL_SLOT_BASE2, `QSEL_SLOT_BASE3,
		`QSEL_SLOT_BASE4, `QSEL_SLOT_BASE5, `QSEL_SLOT_BASE6,
		`QSEL_SLOT_BASE7};
	logic                  ref_clk = 1'b0;
	logic                  nrst = 1'b0;
	logic [3:0]            uart_irq = 4'h0;
	logic [3:0]            second_user_output_n = 4'hF;
	logic                  cfg_sel, cfg_rd, cfg_wr, io_rd, io_wr;
	logic [2:0]            cfg_idx;
	logic [7:0]            cfg_wdata, cfg_rdata, io_rdata;
	logic [15:0]           io_addr;
	logic [3:0]            chan_rd, chan_wr;
	logic                  io_rdata_oe, irq3, irq4, irq9, rd;
	int                    failures = 0;
	int                    num_checks = 0;
	int                    seed = 70;
	qsel_pkg::qsel_byte_t  r2, r3, r4, d;
	qsel_pkg::qsel_addr_t  a;
	logic [8:0]            dec;
	logic [3:0]            g;

	always #5 ref_clk = ~ref_clk;

	qsel_top #(
		.ADAPTER_ID(ID)
	) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .cfg_sel(cfg_sel),
		.cfg_idx(cfg_idx), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_addr(io_addr),
		.io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata),
		.io_rdata_oe(io_rdata_oe), .chan_rd(chan_rd), .chan_wr(chan_wr),
		.uart_irq(uart_irq), .second_user_output_n(second_user_output_n),
		.irq3(irq3), .irq4(irq4), .irq9(irq9)
	);

	qsel_host_model u_host (
		.ref_clk(ref_clk), .cfg_sel(cfg_sel), .cfg_idx(cfg_idx),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .chan_rd(chan_rd), .chan_wr(chan_wr),
		.io_rdata_oe(io_rdata_oe)
	);

	// -------------------------------------------
	// Reference model
	// -------------------------------------------
	function automatic logic [8:0] exp_dec(logic [15:0] ad, logic r);
		logic [3:0] en, hit;
		logic [2:0] code [4];
		logic sp;
		en = {r2[0], r3[7:5]};
		code[0] = r4[3:1];
		code[1] = r4[6:4];
		code[2] = {r3[1:0], r4[7]};
		code[3] = r3[4:2];
		for (int i = 0; i < 4; i++)
		begin
			if (r2[1])
				hit[i] = ad[15:5] == {r3[3:0], r4[7:1]} && ad[4:3] == 2'(i);
			else
				hit[i] = ad[15:3] == SLOT[code[i]][15:3]
					&& code[i] != (i < 2 ? 3'h7 : 3'h0);
		end
		hit = hit & en & {4{r4[0]}};
		sp = r2[7] && ad[2:0] == 3'h7;
		return {r && sp && |hit, hit & {4{r && !sp}}, hit & {4{!r && !sp}}};
	endfunction

	// Order is irq9, irq4, irq3
	function automatic logic [2:0] exp_irq(logic [3:0] gi);
		logic lo, hi;
		lo = |(gi & ~r2[5:2]);
		hi = |(gi & r2[5:2]);
		return {r4[0] & hi & r2[6], r4[0] & hi & ~r2[6], r4[0] & lo};
	endfunction

	// -------------------------------------------
	// Comparisons and verdict
	// -------------------------------------------
	task automatic chk_byte(logic [7:0] got, logic [7:0] exp, string what);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_dec(logic [8:0] got, logic [8:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: strobes %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk_irq(logic [2:0] got, logic [2:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: irq %b not %b", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, well above the run length
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk);
		#1 nrst = 1'b1;
		chk_irq({irq9, irq4, irq3}, 3'h0);
		for (int i = 0; i < 8; i++)
		begin
			if (i < 2 || i > 4)
				u_host.cfg_write(3'(i), 8'($random(seed)));
			u_host.cfg_read(3'(i), d);
			chk_byte(d, i == 0 ? ID[7:0] : i == 1 ? ID[15:8] : 8'h00, "reg");
		end
		$display("test reset_and_id done");
		for (int n = 0; n < 60; n++)
		begin
			r2 = 8'($random(seed));
			r3 = 8'($random(seed));
			r4 = 8'($random(seed));
			// Card left off every eighth pass
			r4[0] = (n % 8) != 0;
			// Fixed passes: slot reads with channel two routed to line nine, then
			// block writes across all four channels
			if (n == 1)
			begin
				r2 = 8'h49;
				r3 = 8'hE4;
				r4 = 8'h91;
			end
			if (n == 2)
			begin
				r2 = 8'h03;
				r3 = 8'hE5;
				r4 = 8'h63;
			end
			u_host.cfg_write(3'h2, r2);
			u_host.cfg_write(3'h3, r3);
			u_host.cfg_write(3'h4, r4);
			for (int i = 2; i < 5; i++)
			begin
				u_host.cfg_read(3'(i), d);
				chk_byte(d, i == 2 ? r2 : i == 3 ? r3 : r4, "reg");
			end
			@(posedge ref_clk);
			#1;
			uart_irq = 4'($random(seed)) | ((n == 1) ? 4'h2 : 4'h0);
			second_user_output_n = 4'($random(seed)) &
				((n == 1) ? 4'hD : 4'hF);
			g = uart_irq & ~second_user_output_n;
			repeat (2) @(posedge ref_clk);
			#1;
			chk_irq({irq9, irq4, irq3}, exp_irq(g));
			chk_byte(io_rdata, {4'h0, g}, "summary");
			for (int k = 0; k < 10; k++)
			begin
				a = 16'($random(seed));
				if (k < 8)
					a[15:3] = SLOT[k][15:3];
				if (k == 8 || n == 2)
					a[15:5] = {r3[3:0], r4[7:1]};
				if (n == 2)
					a[4:3] = 2'(k);
				if (k[0])
					a[2:0] = 3'h7;
				rd = (n == 1) ? 1'b1 : (n == 2) ? 1'b0 : 1'($random(seed));
				u_host.io_cycle(a, rd, dec);
				chk_dec(dec, exp_dec(a, rd));
			end
			chk_byte(io_rdata, {4'h0, g}, "summary");
		end
		$display("test decode_and_irq done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
